// *** dv/ssg_switch_model.sv ***
/*
 Model of the station control switches and the protocol master.
 Assumes the bench sets the wanted switch states on the clock edge.
*/
`default_nettype none
module ssg_switch_model
(
   input wire logic clk_sys, // System clock
   input wire logic [7:0] sw_want, // Wanted closed state per input
   input wire logic use_proto, // Actuate by command, not wiring
   output logic [7:0] contact_in, // Field contacts, closed = 1
   output logic [7:0] proto_cmd // Protocol actuations
);
   timeunit 1ns;
   timeprecision 1ps;
   // One path carries the state; the idle path rests open so it cannot mask it
   always_ff @(posedge clk_sys)
   begin
      contact_in <= use_proto ? 8'h00 : sw_want;
      proto_cmd <= use_proto ? sw_want : 8'h00;
   end
endmodule
`default_nettype wire

// *** dv/tb_ssg_selector.sv ***
/*
 Bench for the settings group selector: groups, priority, config, source.
 Assumes ssg_pkg and the switch model are compiled first.
*/
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
$display("CHECK FAILED at %0t: got %0h exp %0h", $time, g, e); end end
module tb_ssg_selector
   import ssg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, rst = 1'b1, line_tick = 1'b0, cfg_wr = 1'b0;
   logic extended_variant = 1'b0, use_proto = 1'b1;
   logic [7:0] sw_want = 8'h00, contact_in, proto_cmd;
   logic [15:0] alt_one_map = 16'h0001, alt_two_map = 16'h0004;
   logic [10:0] ct_ratio_wr = 11'h001, vt_ratio_wr = 11'h001, ct_ratio, vt_ratio;
   logic [2:0] voltage_transformer_connection_wr = 3'h0, voltage_transformer_connection;
   logic [1:0] active_group, zero_sequence_voltage;
   logic changeover_busy, alternate_one_request, alternate_two_request, cfg_reject;
   int n_errors = 0, samples_checked = 0;
   ssg_switch_model ssg_switch_model_inst (.clk_sys, .sw_want, .use_proto, .contact_in,
      .proto_cmd);
   ssg_selector ssg_selector_inst (.clk_sys, .rst, .line_tick, .contact_in, .proto_cmd,
      .alt_one_map, .alt_two_map, .cfg_wr, .ct_ratio_wr, .vt_ratio_wr, .voltage_transformer_connection_wr,
      .extended_variant, .active_group, .changeover_busy, .alternate_one_request,
      .alternate_two_request, .ct_ratio, .vt_ratio, .voltage_transformer_connection,
      .zero_sequence_voltage, .cfg_reject);
   // Free-running 100 MHz clock
   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Switch model flop plus two sync flops plus forming flop: five edges is ample
   task automatic drive(input logic [7:0] s, input logic [1:0] req);
      @(posedge clk_sys) sw_want <= s;
      repeat (5) @(posedge clk_sys);
      #1 `CHK({alternate_one_request, alternate_two_request}, req)
   endtask
   task automatic tick_once;
      @(posedge clk_sys) line_tick <= 1'b1;
      @(posedge clk_sys) line_tick <= 1'b0;
      #1;
   endtask
   // Old group must hold after one tick, new one appear on the second
   task automatic change(input logic [1:0] g0, input logic [1:0] g1);
      `CHK(changeover_busy, 1'b1)
      if (changeover_busy !== 1'b1) end_of_test;
      tick_once;
      `CHK(active_group, g0)
      tick_once;
      `CHK(active_group, g1)
      `CHK(changeover_busy, 1'b0)
   endtask
   task automatic cfg(input logic [10:0] c, input logic [10:0] v, input logic [2:0] k);
      @(posedge clk_sys)
      begin
         cfg_wr <= 1'b1;
         ct_ratio_wr <= c;
         vt_ratio_wr <= v;
         voltage_transformer_connection_wr <= k;
      end
      @(posedge clk_sys) cfg_wr <= 1'b0;
      #1;
   endtask
   // Requests by protocol; alternate two blocks alternate one until it drops
   task automatic t_groups;
      drive(8'h02, 2'b01);
      change(2'h0, 2'h2);
      drive(8'h03, 2'b11);
      tick_once;
      tick_once;
      `CHK(active_group, 2'h2)
      drive(8'h01, 2'b10);
      change(2'h2, 2'h1);
      drive(8'h00, 2'b00);
      change(2'h1, 2'h0);
      $display("groups test done");
   endtask
   // Contacts: input0 asserts one and suppresses two, input2 ANDed into one
   task automatic t_prio;
      @(posedge clk_sys);
      use_proto <= 1'b0;
      alt_one_map <= 16'h0011;
      alt_two_map <= 16'h0006;
      drive(8'h02, 2'b01);
      change(2'h0, 2'h2);
      drive(8'h03, 2'b00);
      change(2'h2, 2'h0);
      drive(8'h07, 2'b10);
      change(2'h0, 2'h1);
      drive(8'h00, 2'b00);
      change(2'h1, 2'h0);
      $display("priority test done");
   endtask
   // Ratio limits and connection codes; a refused write keeps the old values
   task automatic t_cfg;
      logic [10:0] ct_t[7] = '{11'h7D0, 11'h7D1, 11'h000, 11'h005, 11'h005, 11'h005, 11'h001};
      logic [10:0] vt_t[7] = '{11'h7D0, 11'h005, 11'h005, 11'h000, 11'h7D1, 11'h005, 11'h001};
      logic [2:0] k_t[7] = '{3'h5, 3'h0, 3'h0, 3'h0, 3'h0, 3'h6, 3'h0};
      logic rej_t[7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 7; i++)
      begin
         cfg(ct_t[i], vt_t[i], k_t[i]);
         `CHK(cfg_reject, rej_t[i])
         `CHK(ct_ratio, rej_t[i] ? 11'h7D0 : ct_t[i])
         `CHK(vt_ratio, rej_t[i] ? 11'h7D0 : vt_t[i])
         `CHK(voltage_transformer_connection, rej_t[i] ? 3'h5 : k_t[i])
      end
      $display("config test done");
   endtask
   // Every connection on both hardware variants
   task automatic t_zs;
      logic [1:0] zs_exp;
      for (int v = 0; v < 2; v++)
      begin
         for (int k = 0; k < 6; k++)
         begin
            @(posedge clk_sys) extended_variant <= v[0];
            cfg(11'h001, 11'h001, k[2:0]);
            zs_exp = (k == 0 || k == 2) ? 2'h0 : v ? 2'h1 : k < 4 ? 2'h2 : 2'h3;
            `CHK(zero_sequence_voltage, zs_exp)
         end
      end
      $display("source test done");
   endtask
   // Reset, then each scenario in turn
   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      #1 `CHK(active_group, 2'h0)
      `CHK(ct_ratio, 11'h001)
      t_groups;
      t_prio;
      t_cfg;
      t_zs;
      end_of_test;
   end
endmodule
`default_nettype wire

// *** inc/ssg_pkg.sv ***
/*
 Package for the settings group selector: group, connection and source codes,
 mapping field layout, ratio limits and the changeover delay.
 Assumes a 100 MHz system clock and a line-cycle tick supplied from outside.
*/
// Summary of operation
// [R1] Three settings groups exist; exactly one is active at any time.
// [R2] No alternate request selects primary; a lone request selects its alternate.
// [R3] Alternate two active blocks alternate one until its request drops.
// [R4] A group change completes two power-system cycles after the causing request.
// [R5] Old group stays in force until the new one takes over; never none.
// [R6] Each request maps per input: unmapped, closed-active or open-active.
// [R7] One input may drive several requests at once, giving priority.
// [R8] Several inputs mapped to one request are combined by logical AND.
// [R9] Protection settings are per group; configuration and mappings are common.
// [R10] Protocol commands operate programmable inputs like the contacts.
// [R11] Phase CT ratio accepted only as a whole value from 1 to 2000.
// [R12] VT ratio accepted only as a whole value from 1 to 2000.
// [R13] VT connection offers six choices across 69, 120 and 208 V.
// [R14] Zero-sequence source follows connection and hardware variant.
`default_nettype none
package ssg_pkg;
   localparam int SSG_NUM_IN = 8;
   localparam int SSG_DELAY_CYC = 2;
   localparam logic [10:0] SSG_RATIO_MIN = 11'h001;
   localparam logic [10:0] SSG_RATIO_MAX = 11'h7D0;
   localparam logic [10:0] SSG_RATIO_RST = 11'h001;
   localparam logic [1:0] SSG_MAP_NONE = 2'h0;
   localparam logic [1:0] SSG_MAP_CLOSED = 2'h1;
   localparam logic [1:0] SSG_MAP_OPEN = 2'h2;
   typedef enum logic [1:0] {SSG_GRP_PRIMARY, SSG_GRP_ALT_ONE, SSG_GRP_ALT_TWO} ssg_grp_e;
   typedef enum logic [2:0] {SSG_VT_69_WYE, SSG_VT_69_WYE_RES, SSG_VT_120_WYE,
      SSG_VT_120_WYE_RES, SSG_VT_120_DELTA, SSG_VT_208_DELTA} ssg_vt_e;
   typedef enum logic [1:0] {SSG_ZS_DERIVED, SSG_ZS_SENSOR, SSG_ZS_NOT_APPL,
      SSG_ZS_ZERO} ssg_zs_e;
endpackage
`default_nettype wire

// *** logic/ssg_selector.sv ***
/*
 Settings group selector: forms the two alternate requests from mapped
 contact and protocol inputs, arbitrates the active group with a two
 line-cycle changeover and checks the common configuration settings.
 Assumes line_tick pulses once per power-system cycle on clk_sys, and that
 config writes are presented as a one-cycle strobe from the same domain.
*/
`default_nettype none
module ssg_selector
   import ssg_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic line_tick, // One pulse per power-system cycle
   input wire logic [SSG_NUM_IN-1:0] contact_in, // Raw contact inputs, closed = 1
   input wire logic [SSG_NUM_IN-1:0] proto_cmd, // Protocol command actuation
   input wire logic [2*SSG_NUM_IN-1:0] alt_one_map, // Two bits per input
   input wire logic [2*SSG_NUM_IN-1:0] alt_two_map, // Two bits per input
   input wire logic cfg_wr, // Config write strobe
   input wire logic [10:0] ct_ratio_wr, // Proposed CT ratio
   input wire logic [10:0] vt_ratio_wr, // Proposed VT ratio
   input wire logic [2:0] voltage_transformer_connection_wr, // Proposed VT connection
   input wire logic extended_variant, // Residual sensor fitted
   output logic [1:0] active_group, // Active group code
   output logic changeover_busy, // Change pending
   output logic alternate_one_request, // Formed request one
   output logic alternate_two_request, // Formed request two
   output logic [10:0] ct_ratio, // Accepted CT ratio
   output logic [10:0] vt_ratio, // Accepted VT ratio
   output logic [2:0] voltage_transformer_connection, // Accepted connection
   output logic [1:0] zero_sequence_voltage, // Zero-sequence source code
   output logic cfg_reject // Last write refused
);
   typedef struct packed {
      logic [SSG_NUM_IN-1:0] in_s1;
      logic [SSG_NUM_IN-1:0] in_s2;
      logic req_one;
      logic req_two;
      ssg_grp_e grp;
      ssg_grp_e target;
      logic [1:0] cnt;
      logic [10:0] ct;
      logic [10:0] vt;
      ssg_vt_e conn;
      logic rej;
   } ssg_state_s;

   ssg_state_s st_q;
   ssg_state_s st_d;

   // AND of polarity-adjusted mapped inputs; unmapped request stays low
   function automatic logic ssg_form_req(input logic [SSG_NUM_IN-1:0] lvl,
                                         input logic [2*SSG_NUM_IN-1:0] map);
      logic any;
      logic all_ok;
      any = 1'b0;
      all_ok = 1'b1;
      for (int i = 0; i < SSG_NUM_IN; i++)
      begin
         if (map[2*i +: 2] == SSG_MAP_CLOSED)
         begin
            any = 1'b1;
            all_ok = all_ok & lvl[i];
         end
         else if (map[2*i +: 2] == SSG_MAP_OPEN)
         begin
            any = 1'b1;
            all_ok = all_ok & ~lvl[i];
         end
      end
      return any & all_ok;
   endfunction

   function automatic logic ssg_ratio_ok(input logic [10:0] r);
      return (r >= SSG_RATIO_MIN) && (r <= SSG_RATIO_MAX);
   endfunction

   ssg_grp_e want;
   logic [SSG_NUM_IN-1:0] lvl;

   // Next-state logic for the whole selector
   always_comb
   begin
      st_d = st_q;
      st_d.in_s1 = contact_in;
      st_d.in_s2 = st_q.in_s1;
      // Protocol actuation is already on our clock, so it joins after the contact sync
      lvl = st_q.in_s2 | proto_cmd; // R10
      st_d.req_one = ssg_form_req(lvl, alt_one_map); // R6 R7 R8
      st_d.req_two = ssg_form_req(lvl, alt_two_map); // R6 R7 R8
      // Arbitration keeps the held alternate until its own request drops
      want = SSG_GRP_PRIMARY; // R2
      if (st_q.grp == SSG_GRP_ALT_TWO && st_q.req_two)
         want = SSG_GRP_ALT_TWO; // R3
      else if (st_q.grp == SSG_GRP_ALT_ONE && st_q.req_one)
         want = SSG_GRP_ALT_ONE;
      else if (st_q.req_one)
         want = SSG_GRP_ALT_ONE; // R2
      else if (st_q.req_two)
         want = SSG_GRP_ALT_TWO; // R2
      // Old group stays in force while the delay runs, so protection never lapses
      if (want == st_q.grp)
      begin
         st_d.target = st_q.grp;
         st_d.cnt = 2'h0;
      end
      else if (want != st_q.target)
      begin
         st_d.target = want; // R4
         st_d.cnt = 2'h0;
      end
      else if (line_tick)
      begin
         if (st_q.cnt == 2'(SSG_DELAY_CYC - 1))
         begin
            st_d.grp = st_q.target; // R4 R5 R1
            st_d.cnt = 2'h0;
         end
         else
            st_d.cnt = st_q.cnt + 2'h1;
      end
      // Common configuration, one copy whatever group runs
      if (cfg_wr)
      begin
         if (ssg_ratio_ok(ct_ratio_wr) && ssg_ratio_ok(vt_ratio_wr) // R11 R12
             && voltage_transformer_connection_wr <= 3'(SSG_VT_208_DELTA)) // R13
         begin
            st_d.ct = ct_ratio_wr; // R9
            st_d.vt = vt_ratio_wr;
            st_d.conn = ssg_vt_e'(voltage_transformer_connection_wr);
            st_d.rej = 1'b0;
         end
         else
            st_d.rej = 1'b1;
      end
      if (rst)
      begin
         st_d = '0;
         st_d.ct = SSG_RATIO_RST;
         st_d.vt = SSG_RATIO_RST;
      end
   end

   // Single state register
   always_ff @(posedge clk_sys)
      st_q <= st_d;

   // Zero-sequence source from connection and variant
   always_comb
   begin
      case (st_q.conn)
         SSG_VT_69_WYE, SSG_VT_120_WYE: zero_sequence_voltage = SSG_ZS_DERIVED; // R14
         SSG_VT_69_WYE_RES, SSG_VT_120_WYE_RES:
            zero_sequence_voltage = extended_variant ? SSG_ZS_SENSOR : SSG_ZS_NOT_APPL; // R14
         SSG_VT_120_DELTA, SSG_VT_208_DELTA:
            zero_sequence_voltage = extended_variant ? SSG_ZS_SENSOR : SSG_ZS_ZERO; // R14
         default: zero_sequence_voltage = SSG_ZS_DERIVED;
      endcase
   end

   assign active_group = st_q.grp;
   assign changeover_busy = (st_q.target != st_q.grp);
   assign alternate_one_request = st_q.req_one;
   assign alternate_two_request = st_q.req_two;
   assign ct_ratio = st_q.ct;
   assign vt_ratio = st_q.vt;
   assign voltage_transformer_connection = st_q.conn;
   assign cfg_reject = st_q.rej;

   // Group code never leaves the three legal values
   one_group_a: assert property (@(posedge clk_sys) disable iff (rst) // R1
      st_q.grp != 2'h3) else $error("illegal group code");
   // Held alternate two stays put; no change without a completed delay
   hold_two_a: assert property (@(posedge clk_sys) disable iff (rst) // R3
      (st_q.grp == SSG_GRP_ALT_TWO && st_q.req_two) |=> st_q.grp == SSG_GRP_ALT_TWO)
      else $error("alternate two dropped while requested");
   delay_a: assert property (@(posedge clk_sys) disable iff (rst) // R4
      $changed(st_q.grp) |-> $past(line_tick) && $past(st_q.cnt) == 2'h1)
      else $error("group changed without two-cycle delay");
   primary_a: assert property (@(posedge clk_sys) disable iff (rst) // R2
      (!st_q.req_one && !st_q.req_two && st_q.grp == SSG_GRP_PRIMARY) |=>
      st_q.grp == SSG_GRP_PRIMARY) else $error("left primary without request");
   ct_range_a: assert property (@(posedge clk_sys) disable iff (rst) // R11
      ct_ratio >= SSG_RATIO_MIN && ct_ratio <= SSG_RATIO_MAX) else $error("CT ratio out of range");
   vt_range_a: assert property (@(posedge clk_sys) disable iff (rst) // R12
      vt_ratio >= SSG_RATIO_MIN && vt_ratio <= SSG_RATIO_MAX) else $error("VT ratio out of range");
   conn_a: assert property (@(posedge clk_sys) disable iff (rst) // R13
      voltage_transformer_connection <= 3'h5) else $error("bad VT connection");
   zs_a: assert property (@(posedge clk_sys) disable iff (rst) // R14
      (!extended_variant && voltage_transformer_connection >= 3'h4) |->
      zero_sequence_voltage == SSG_ZS_ZERO) else $error("delta source not zero");
   bad_wr_a: assert property (@(posedge clk_sys) disable iff (rst) // R11
      (cfg_wr && ct_ratio_wr == 11'h000) |=> cfg_reject && $stable(ct_ratio))
      else $error("illegal write accepted");
   // Last counted tick of a changeover whose target still stands
   sequence final_tick_s;
      changeover_busy && line_tick && st_q.cnt == 2'h1 && want == st_q.target;
   endsequence
   // A pending change between ticks, while the old group must stay in force
   sequence between_ticks_s;
      changeover_busy && !line_tick;
   endsequence
   // The second counted tick hands over to the latched target
   swap_a: assert property (@(posedge clk_sys) disable iff (rst) // R4
      final_tick_s |=> active_group == $past(st_q.target))
      else $error("changeover missed its second tick");
   // Old group holds until the tick that ends the delay, so protection never lapses
   no_early_a: assert property (@(posedge clk_sys) disable iff (rst) // R5
      between_ticks_s |=> $stable(active_group))
      else $error("group changed between line ticks");
   // Without a pending change the active group cannot move
   idle_keep_a: assert property (@(posedge clk_sys) disable iff (rst) // R1
      !changeover_busy |=> $stable(active_group))
      else $error("group moved with no change pending");
   // A held alternate two is not displaced by a new alternate one request
   alt_two_lock_a: assert property (@(posedge clk_sys) disable iff (rst) // R3
      (active_group == SSG_GRP_ALT_TWO && alternate_two_request && alternate_one_request)
      |=> !changeover_busy) else $error("alternate one displaced held alternate two");
   // Each new changeover starts its tick count from zero
   busy_start_a: assert property (@(posedge clk_sys) disable iff (rst) // R4
      $rose(changeover_busy) |-> st_q.cnt == 2'h0)
      else $error("changeover started with stale count");
   // Common settings change only through a write, whichever group runs
   cfg_keep_a: assert property (@(posedge clk_sys) disable iff (rst) // R9
      !cfg_wr |=> $stable(ct_ratio) && $stable(vt_ratio)
      && $stable(voltage_transformer_connection))
      else $error("configuration changed without a write");
endmodule
`default_nettype wire
